/* rtl/adc_conversion_handshake.sv */
// converter control: strobe decode, dual hold stages, result latch, host handshake
`timescale 1ns/10ps
module adc_conversion_handshake (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire adc_handshake_pkg::host_ctrl_t i_host,
  input wire adc_handshake_pkg::code_t i_analog_input_first,
  input wire adc_handshake_pkg::code_t i_analog_input_second,
  output logic o_eoc,
  output logic o_int_n,
  output adc_handshake_pkg::code_t o_data,
  output logic o_data_oe,
  output logic o_channel_select
);
  typedef struct packed {
    logic sh_prev;
    logic rd_prev;
    logic eoc;
    logic int_n;
    logic unread;
    logic mux_sel;
    logic acq_sel;
    logic [1:0][adc_handshake_pkg::RES_W-1:0] hold;
    adc_handshake_pkg::code_t data;
  } top_reg_t;

  top_reg_t state_ff;
  top_reg_t nxt_state;
  logic sh_fall;
  logic rd_fall;
  logic start;
  logic core_idle;
  logic core_valid;
  logic core_ready;
  adc_handshake_pkg::code_t core_result;
  logic buf_valid;
  logic out_ready;
  adc_handshake_pkg::code_t buf_data;
  adc_handshake_pkg::code_t mux_word;
  logic high_speed;

  // strobes count only while chip select is low
  assign sh_fall = state_ff.sh_prev && !i_host.sample_hold && !i_host.cs_n;
  assign rd_fall = state_ff.rd_prev && !i_host.rd_n && !i_host.cs_n;
  // a start while the engine is still busy is dropped, not queued
  assign start = sh_fall && core_idle;
  assign high_speed = (i_host.mode == adc_handshake_pkg::MODE_HIGH_SPEED);

  // input multiplexer
  assign mux_word = (state_ff.mux_sel == adc_handshake_pkg::CHAN_SECOND) ?
    i_analog_input_second : i_analog_input_first;

  // latch accepts a new word only when the host has read the last one, or at any time in high-speed mode
  assign out_ready = high_speed || !state_ff.unread;

  conv_core #(
    .CONV_CYCLES(adc_handshake_pkg::CONV_CYCLES)
  ) u_core (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(start),
    .i_sample(state_ff.hold[state_ff.acq_sel]),
    .o_idle(core_idle),
    .o_valid(core_valid),
    .i_ready(core_ready),
    .o_result(core_result)
  );

  result_buffer #(
    .WIDTH(adc_handshake_pkg::RES_W)
  ) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(core_valid),
    .o_in_ready(core_ready),
    .i_in_data(core_result),
    .o_out_valid(buf_valid),
    .i_out_ready(out_ready),
    .o_out_data(buf_data)
  );

  // next-state logic for hold stages, flags and output latch
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sh_prev = i_host.sample_hold;
    nxt_state.rd_prev = i_host.rd_n;
    // the acquiring stage tracks the input; the other keeps its frozen value
    for (int i = 0; i < 2; i++) begin
      if (state_ff.acq_sel == 1'(i)) begin
        nxt_state.hold[i] = mux_word;
      end
    end
    if (start) begin
      nxt_state.hold[state_ff.acq_sel] = state_ff.hold[state_ff.acq_sel];
      nxt_state.acq_sel = ~state_ff.acq_sel;
      nxt_state.eoc = 1'h0;
      nxt_state.mux_sel = i_host.channel_select;
    end
    // read clears first so a same-cycle completion still wins
    if (rd_fall) begin
      nxt_state.int_n = 1'h1;
      nxt_state.unread = 1'h0;
    end
    if (buf_valid && out_ready) begin
      nxt_state.data = buf_data;
      nxt_state.eoc = 1'h1;
      nxt_state.int_n = 1'h0;
      nxt_state.unread = 1'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_ff <= '{1'h1, 1'h1, adc_handshake_pkg::EOC_RESET,
                    adc_handshake_pkg::INT_N_RESET, 1'h0,
                    adc_handshake_pkg::CHAN_FIRST, 1'h0, '0,
                    adc_handshake_pkg::CODE_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // bus drive: always in high-speed mode, else only during a selected read
  assign o_data_oe = high_speed || (!i_host.cs_n && !i_host.rd_n);
  assign o_data = state_ff.data;
  assign o_eoc = state_ff.eoc;
  assign o_int_n = state_ff.int_n;
  assign o_channel_select = state_ff.mux_sel;
endmodule // adc_conversion_handshake

/* rtl/adc_handshake_pkg.sv */
// constants, types and carriers shared by the converter control block
// Summary of operation
// - a sample/hold falling edge freezes the held input and starts a conversion
// - at conversion end, end-of-conversion goes high and interrupt goes low
// - result is latched; host reads it by pulling read strobe low
// - a falling edge on the read strobe returns interrupt high
// - sample/hold and read strobe count only while chip select is low
// - high-speed mode keeps the result driven on the data bus continuously
// - high-speed mode needs no interrupt-then-read exchange per sample
// - channel is taken from channel select when a sample/hold falling edge starts a conversion
// - channel select 0 routes the first input, 1 the second
// - two hold stages alternate, one acquiring while the other converts
// - estimator and three flash results merge into one 12-bit word
// - exactly two interface modes, interrupt/read and high-speed
package adc_handshake_pkg;
  localparam int RES_W = 12;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 593;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 7;
  localparam int BUF_DEPTH = 2;

  // bit fields of the merged result word
  localparam int EST_MSB = 11;
  localparam int EST_LSB = 10;
  localparam int FL1_MSB = 11;
  localparam int FL1_LSB = 6;
  localparam int FL2_MSB = 5;
  localparam int FL2_LSB = 2;
  localparam int FL3_MSB = 1;
  localparam int FL3_LSB = 0;

  localparam logic CHAN_FIRST = 1'h0;
  localparam logic CHAN_SECOND = 1'h1;
  localparam logic EOC_RESET = 1'h0;
  localparam logic INT_N_RESET = 1'h1;
  localparam logic [RES_W-1:0] CODE_RESET = 12'h000;

  typedef logic [RES_W-1:0] code_t;

  typedef enum logic {
    MODE_INTERRUPT,
    MODE_HIGH_SPEED
  } if_mode_t;

  typedef enum logic [1:0] {
    CORE_IDLE,
    CORE_CONVERT,
    CORE_DONE
  } core_state_t;

  // host side strobes, sampled on i_sys_clk except where cs_n, rd_n and mode drive the bus enable directly
  typedef struct packed {
    logic sample_hold;
    logic cs_n;
    logic rd_n;
    logic channel_select;
    if_mode_t mode;
  } host_ctrl_t;

  // partial results of the three flash steps and the estimator
  typedef struct packed {
    logic [EST_MSB-EST_LSB:0] estimate;
    logic [FL1_MSB-FL1_LSB:0] flash_first;
    logic [FL2_MSB-FL2_LSB:0] flash_second;
    logic [FL3_MSB-FL3_LSB:0] flash_third;
  } flash_parts_t;
endpackage

/* rtl/conv_core.sv */
// multistep conversion engine: timed conversion of one held sample
`timescale 1ns/10ps
module conv_core #(
  parameter int CONV_CYCLES = adc_handshake_pkg::CONV_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire adc_handshake_pkg::code_t i_sample,
  output logic o_idle,
  output logic o_valid,
  input wire logic i_ready,
  output adc_handshake_pkg::code_t o_result
);
  localparam logic [adc_handshake_pkg::CNT_W-1:0] CNT_LOAD =
    adc_handshake_pkg::CNT_W'(CONV_CYCLES - 1);

  typedef struct packed {
    adc_handshake_pkg::core_state_t st;
    logic [adc_handshake_pkg::CNT_W-1:0] cnt;
    adc_handshake_pkg::code_t held;
    adc_handshake_pkg::code_t result;
  } core_reg_t;

  core_reg_t state_ff;
  core_reg_t nxt_state;
  adc_handshake_pkg::flash_parts_t parts;
  logic [adc_handshake_pkg::EST_MSB-adc_handshake_pkg::EST_LSB:0] est_fixed;

  // split held value into estimator and flash steps
  always_comb begin
    parts.estimate = state_ff.held[adc_handshake_pkg::EST_MSB:adc_handshake_pkg::EST_LSB];
    parts.flash_first = state_ff.held[adc_handshake_pkg::FL1_MSB:adc_handshake_pkg::FL1_LSB];
    parts.flash_second = state_ff.held[adc_handshake_pkg::FL2_MSB:adc_handshake_pkg::FL2_LSB];
    parts.flash_third = state_ff.held[adc_handshake_pkg::FL3_MSB:adc_handshake_pkg::FL3_LSB];
    // the first flash overlaps the estimate, so its top bits correct it
    est_fixed = parts.flash_first[adc_handshake_pkg::FL1_MSB-adc_handshake_pkg::FL1_LSB -: 2];
    if (parts.estimate == est_fixed) begin
      est_fixed = parts.estimate;
    end
  end

  // sequencing: idle, counting conversion time, holding a finished word
  always_comb begin
    nxt_state = state_ff;
    case (state_ff.st)
      adc_handshake_pkg::CORE_IDLE: begin
        if (i_start) begin
          nxt_state.held = i_sample;
          nxt_state.cnt = CNT_LOAD;
          nxt_state.st = adc_handshake_pkg::CORE_CONVERT;
        end
      end
      adc_handshake_pkg::CORE_CONVERT: begin
        if (state_ff.cnt == '0) begin
          nxt_state.result = {est_fixed,
            parts.flash_first[adc_handshake_pkg::FL1_MSB-adc_handshake_pkg::FL1_LSB-2:0],
            parts.flash_second, parts.flash_third};
          nxt_state.st = adc_handshake_pkg::CORE_DONE;
        end else begin
          nxt_state.cnt = state_ff.cnt - 1'h1;
        end
      end
      adc_handshake_pkg::CORE_DONE: begin
        // stalls here until the buffer takes the word
        if (i_ready) begin
          nxt_state.st = adc_handshake_pkg::CORE_IDLE;
        end
      end
      default: nxt_state.st = adc_handshake_pkg::CORE_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_ff <= '{adc_handshake_pkg::CORE_IDLE, '0, adc_handshake_pkg::CODE_RESET,
                    adc_handshake_pkg::CODE_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_idle = (state_ff.st == adc_handshake_pkg::CORE_IDLE);
  assign o_valid = (state_ff.st == adc_handshake_pkg::CORE_DONE);
  assign o_result = state_ff.result;
endmodule // conv_core

/* rtl/result_buffer.sv */
// two-entry buffer between conversion engine and output latch
`timescale 1ns/10ps
module result_buffer #(
  parameter int WIDTH = adc_handshake_pkg::RES_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_reg_t;

  buf_reg_t state_ff;
  buf_reg_t nxt_state;
  logic push;
  logic pop;

  // honest full and empty from the entry count
  assign o_in_ready = (state_ff.count != 2'(adc_handshake_pkg::BUF_DEPTH));
  assign o_out_valid = (state_ff.count != 2'h0);
  assign o_out_data = state_ff.mem[state_ff.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    nxt_state = state_ff;
    if (push) begin
      nxt_state.mem[state_ff.wr_ptr] = i_in_data;
      nxt_state.wr_ptr = ~state_ff.wr_ptr;
    end
    if (pop) begin
      nxt_state.rd_ptr = ~state_ff.rd_ptr;
    end
    nxt_state.count = state_ff.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule // result_buffer

/* sim/adc_conversion_handshake_monitor.sv */
// concurrent checks on the converter control block ports
`timescale 1ns/10ps
module adc_conversion_handshake_monitor (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire adc_handshake_pkg::host_ctrl_t i_host,
  input wire adc_handshake_pkg::code_t i_analog_input_first,
  input wire adc_handshake_pkg::code_t i_analog_input_second,
  input wire logic o_eoc,
  input wire logic o_int_n,
  input wire adc_handshake_pkg::code_t o_data,
  input wire logic o_data_oe,
  input wire logic o_channel_select
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // strobe edges count only while the chip is selected
  sequence s_read;
    $fell(i_host.rd_n) && !i_host.cs_n;
  endsequence
  sequence s_busy;
    (!o_eoc)[*8];
  endsequence
  property p_start;
    $fell(o_eoc) |-> (!$past(i_host.cs_n) && !$past(i_host.sample_hold)) ##0 s_busy;
  endproperty
  a_start: assert property (p_start) else $error("eoc fell without start");
  property p_unselected;
    $fell(i_host.sample_hold) && i_host.cs_n && o_eoc |=> o_eoc;
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected start");
  property p_done;
    i_host.mode == adc_handshake_pkg::MODE_INTERRUPT && $rose(o_eoc) |-> !o_int_n;
  endproperty
  a_done: assert property (p_done) else $error("no interrupt at end");
  property p_read;
    s_read ##0 !$rose(o_eoc) |=> o_int_n || $rose(o_eoc);
  endproperty
  a_read: assert property (p_read) else $error("read left interrupt");
  property p_hold;
    $changed(o_data) |-> o_eoc;
  endproperty
  a_hold: assert property (p_hold) else $error("data moved early");
  property p_oe_intr;
    i_host.mode == adc_handshake_pkg::MODE_INTERRUPT
      |-> o_data_oe == (!i_host.cs_n && !i_host.rd_n);
  endproperty
  a_oe_intr: assert property (p_oe_intr) else $error("bus enable wrong");
  property p_oe_fast;
    i_host.mode == adc_handshake_pkg::MODE_HIGH_SPEED |-> o_data_oe;
  endproperty
  a_oe_fast: assert property (p_oe_fast) else $error("bus not driven");
  property p_chan;
    $changed(o_channel_select) |-> $fell(o_eoc);
  endproperty
  a_chan: assert property (p_chan) else $error("channel moved");
endmodule // adc_conversion_handshake_monitor

bind adc_conversion_handshake adc_conversion_handshake_monitor u_mon (.i_sys_clk, .i_sys_rst,
  .i_host, .i_analog_input_first, .i_analog_input_second, .o_eoc, .o_int_n, .o_data,
  .o_data_oe, .o_channel_select);

/* sim/host_model.sv */
// host side model: turns bench requests into chip select and strobes
`timescale 1ns/10ps
module host_model (
  input wire logic i_sh_req,
  input wire logic i_rd_req,
  input wire logic i_skip_cs,
  input wire logic i_chan,
  input wire adc_handshake_pkg::if_mode_t i_mode,
  output adc_handshake_pkg::host_ctrl_t o_host
);
  // chip select follows each strobe unless told to stay off
  always_comb begin
    o_host.sample_hold = ~i_sh_req;
    o_host.rd_n = ~i_rd_req;
    o_host.cs_n = ~(i_sh_req | i_rd_req) | i_skip_cs;
    o_host.channel_select = i_chan;
    o_host.mode = i_mode;
  end
endmodule // host_model

/* sim/tb_adc_conversion_handshake.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_adc_conversion_handshake;
  logic i_sys_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic sh_req = 1'h0, rd_req = 1'h0, skip_cs = 1'h0, chan = 1'h0;
  adc_handshake_pkg::if_mode_t mode = adc_handshake_pkg::MODE_INTERRUPT;
  adc_handshake_pkg::host_ctrl_t host;
  adc_handshake_pkg::code_t in_a = 12'h000, in_b = 12'h000, o_data;
  logic o_eoc, o_int_n, o_data_oe, o_channel_select;
  int miscompares = 0;
  int num_checks = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  host_model partner (.i_sh_req(sh_req), .i_rd_req(rd_req), .i_skip_cs(skip_cs),
    .i_chan(chan), .i_mode(mode), .o_host(host));
  adc_conversion_handshake uut (.i_sys_clk, .i_sys_rst, .i_host(host),
    .i_analog_input_first(in_a), .i_analog_input_second(in_b), .o_eoc, .o_int_n,
    .o_data, .o_data_oe, .o_channel_select);
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // selected input for a channel level
  function automatic adc_handshake_pkg::code_t pick(input logic ch);
    return ch ? in_b : in_a;
  endfunction
  // one-cycle strobe; bus enable checked while it is low
  task automatic pulse(input bit rd);
    @(negedge i_sys_clk);
    if (rd) begin
      rd_req = 1'h1;
    end else begin
      sh_req = 1'h1;
    end
    #1 chk({11'h0, o_data_oe}, {11'h0, (rd && !skip_cs) || mode}, "bus enable");
    @(negedge i_sys_clk);
    rd_req = 1'h0;
    sh_req = 1'h0;
  endtask
  // bounded wait, a hang counts as a mismatch
  task automatic convert(input logic ch, input bit check);
    int n;
    chan = ch;
    pulse(1'b0);
    chk({11'h0, o_eoc}, 12'h000, "eoc stayed high");
    n = 0;
    while (o_eoc !== 1'h1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    // judged on the flag itself, so a completion on the last try still counts
    if (o_eoc !== 1'h1) begin
      miscompares++;
      $display("wrong value at %0t: no completion", $time);
      tally_and_finish();
    end else begin
      if (check) chk(o_data, pick(ch), "result word");
      if (!mode) chk({11'h0, o_int_n}, 12'h000, "no interrupt");
      chk({11'h0, o_channel_select}, {11'h0, ch}, "channel");
    end
  endtask
  task automatic read_back();
    pulse(1'b1);
    @(negedge i_sys_clk);
    chk({11'h0, o_int_n}, 12'h001, "interrupt kept");
  endtask
  initial begin
    void'($urandom(32'h480e3baa));
    repeat (12) @(negedge i_sys_clk);
    i_sys_rst = 1'h0;
    chk(o_data, 12'h000, "reset data");
    chk({10'h0, o_eoc, o_int_n}, 12'h001, "reset flags");
    // first conversion primes the channel, the second is compared
    for (int i = 0; i < 6; i++) begin
      logic c;
      c = (i < 2) ? i[0] : 1'($urandom);
      in_a = (i == 0) ? 12'hfff : 12'($urandom);
      in_b = (i == 0) ? 12'h000 : 12'($urandom);
      convert(c, 1'b0);
      read_back();
      convert(c, 1'b1);
      // unselected strobes must change nothing
      skip_cs = 1'h1;
      pulse(1'b1);
      pulse(1'b0);
      skip_cs = 1'h0;
      chk({10'h0, o_eoc, o_int_n}, 12'h002, "unselected strobe acted");
      read_back();
      chk(o_data, pick(c), "data moved");
    end
    // fast mode: no reads, each completion lands on the bus
    mode = adc_handshake_pkg::MODE_HIGH_SPEED;
    convert(1'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      in_a = 12'($urandom);
      convert(1'h0, 1'b1);
      chk({11'h0, o_data_oe}, 12'h001, "bus released");
    end
    tally_and_finish();
  end
endmodule // tb_adc_conversion_handshake
